//--- logic/hpk_consts.svh
// Constants of the haptic playback-mode sequencer: offsets, fields, resets, timing.
// Included by the package users; definitions only.
`ifndef HPK_CONSTS_SVH
`define HPK_CONSTS_SVH

// Device register offsets on the serial link
`define HPK_OFS_MODE 7'h01
`define HPK_OFS_RTP 7'h02
`define HPK_OFS_LIB 7'h03
`define HPK_OFS_SLOT_FIRST 7'h04
`define HPK_OFS_SLOT_LAST 7'h0b
`define HPK_OFS_FIRE 7'h0c
`define HPK_OFS_CFG_A 7'h1b
`define HPK_OFS_CFG_B 7'h1c
`define HPK_OFS_CFG_C 7'h1d
`define HPK_OFS_STAT 7'h1e
`define HPK_OFS_PERIOD 7'h22

// Field positions
`define HPK_MODE_STANDBY_BIT 6
`define HPK_CFG_B_BIDIR_BIT 7
`define HPK_CFG_C_OPEN_LOOP_BIT 0
`define HPK_CFG_C_ANALOG_BIT 1
`define HPK_STAT_NVM_BIT 2

// Operating-mode field encodings
`define HPK_MODE_SW_TRIG 3'h0
`define HPK_MODE_EDGE_TRIG 3'h1
`define HPK_MODE_LEVEL_TRIG 3'h2
`define HPK_MODE_EXT_INPUT 3'h3
`define HPK_MODE_REALTIME 3'h5

// Reset values
`define HPK_RST_MODE 8'h40
`define HPK_RST_CFG_A 8'h00
`define HPK_RST_CFG_B 8'h80
`define HPK_RST_CFG_C 8'h00

// Timing: clock rate and power-up hold-off
`define HPK_CLK_MHZ 50
`define HPK_POWERUP_US 250
`define HPK_POWERUP_CYC (`HPK_POWERUP_US * `HPK_CLK_MHZ)
`define HPK_EFFECT_CYC 1000
`define HPK_LINK_HALF_CYC 16

// Host AHB-Lite register offsets
`define HPK_HOFS_CTRL 8'h00
`define HPK_HOFS_CMD 8'h04
`define HPK_HOFS_STATUS 8'h08

`endif

//--- logic/hpk_pkg.sv
// Types shared by both ends of the haptic sequencer link.
// Assumes nothing beyond a SystemVerilog compiler.
package hpk_pkg;
    typedef enum logic [1:0] {HPK_PLAY_IDLE, HPK_PLAY_RUN} hpk_play_e;
    typedef enum logic [1:0] {HPK_LNK_IDLE, HPK_LNK_SHIFT, HPK_LNK_END} hpk_lnk_e;
    typedef logic [7:0] hpk_byte_t;
endpackage : hpk_pkg

//--- logic/hpk_link_if.sv
// Link between host controller and haptic device: serial frame port plus pins.
// Assumes the bench joins the two ends; all wires are push-pull, host to device except miso.
`timescale 1ns/10ps
interface hpk_link_if;
    logic lnk_clk;
    logic lnk_sel_n;
    logic lnk_mosi;
    logic lnk_miso;
    logic enable_pin;
    logic input_trigger_pin;

    modport device (
        input lnk_clk, lnk_sel_n, lnk_mosi, enable_pin, input_trigger_pin,
        output lnk_miso
    );
    modport host (
        output lnk_clk, lnk_sel_n, lnk_mosi, enable_pin, input_trigger_pin,
        input lnk_miso
    );
endinterface : hpk_link_if

//--- logic/hpk_device.sv
// Haptic device end: register file over the serial link, mode decode, sequencer.
// Assumes link pins come from another domain; analog level is sampled on hclk.
// Operation
// - Commands ignored until 250 us after power-up
// - Host may raise enable anytime
// - Mode write 0x00 leaves standby
// - Host skips calibration when memory programmed
// - Host selects library at offset 0x03
// - Reset default is closed-loop bidirectional drive
// - Host prefers open loop for rotating mass
// - One write sets standby and mode together
// - Mode 0 software, 1 edge, 2 level
// - Host clears standby when selecting mode
// - Play slot 0x04, sequence through 0x0B
// - Fire bit starts playback in mode 0
// - Trigger pin starts playback in modes 1,2
// - Repeat trigger replays without rewriting slots
// - Mode 5 selects real-time amplitude playback
// - Each written amplitude is driven directly
// - Mode 3 selects external input playback
// - Config bit picks PWM or analog input
// - Enable low or standby gives low power
// - Tracker locks in half cycle, follows
// - Tracking needs no calibration, stays independent
// - Status bit shows calibration memory programmed
`timescale 1ns/10ps
`include "hpk_consts.svh"
module hpk_device import hpk_pkg::*; #(
    parameter int POWERUP_CYC = `HPK_POWERUP_CYC,
    parameter int EFFECT_CYC = `HPK_EFFECT_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link to host
    hpk_link_if.device lnk,
    // Device pins and analog front end
    input wire logic nvm_programmed,
    input wire logic bemf_zero_cross,
    input wire logic [7:0] analog_level,
    // Drive stage
    output logic [7:0] drive_level_o,
    output logic [7:0] effect_index_o,
    output logic [7:0] effect_library_o,
    output logic drive_active_o,
    output logic drive_polarity_o,
    output logic drive_open_loop_o,
    output logic drive_bidir_o,
    output logic low_power_o
);
    localparam int NSYNC = 7;

    // Three-stage synchronisers; a bit changes once stages two and three agree
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, filt_ff, prev_ff;
    assign pins = {lnk.lnk_clk, lnk.lnk_sel_n, lnk.lnk_mosi, lnk.enable_pin,
                   lnk.input_trigger_pin, nvm_programmed, bemf_zero_cross};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_ff <= 7'h20;
            s2_ff <= 7'h20;
            s3_ff <= 7'h20;
            filt_ff <= 7'h20;
            prev_ff <= 7'h20;
        end else begin
            s1_ff <= pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
            prev_ff <= filt_ff;
        end
    end
    wire f_clk = filt_ff[6];
    wire f_sel_n = filt_ff[5];
    wire f_mosi = filt_ff[4];
    wire f_en = filt_ff[3];
    wire f_trig = filt_ff[2];
    wire f_nvm = filt_ff[1];
    wire zc_edge = filt_ff[0] ^ prev_ff[0];
    wire clk_rise = f_clk & ~prev_ff[6];
    wire clk_fall = ~f_clk & prev_ff[6];
    wire sel_fall = ~f_sel_n & prev_ff[5];
    wire sel_rise = f_sel_n & ~prev_ff[5];
    wire trig_rise = f_trig & ~prev_ff[2];

    // Power-up hold-off
    logic [$clog2(POWERUP_CYC+1)-1:0] pu_cnt_ff;
    logic pu_done_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pu_cnt_ff <= '0;
            pu_done_ff <= 1'b0;
        end else if (!pu_done_ff) begin
            pu_cnt_ff <= pu_cnt_ff + 1'b1;
            pu_done_ff <= (pu_cnt_ff == ($clog2(POWERUP_CYC+1))'(POWERUP_CYC - 1));
        end
    end

    // Serial frame: bit 15 read flag, bits 14:8 offset, bits 7:0 data
    logic [4:0] bit_cnt_ff;
    logic [15:0] shift_ff;
    logic [7:0] rd_ff;
    logic miso_ff;
    logic [7:0] rd_data;
    wire link_on = pu_done_ff & f_en;
    wire [6:0] rx_addr = shift_ff[14:8];
    wire [6:0] hdr_addr = shift_ff[6:0];
    wire wr_stb = link_on & sel_rise & (bit_cnt_ff == 5'd16) & ~shift_ff[15];
    wire [7:0] wr_data = shift_ff[7:0];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt_ff <= '0;
            shift_ff <= '0;
            rd_ff <= '0;
            miso_ff <= 1'b0;
        end else if (sel_fall) begin
            bit_cnt_ff <= '0;
        end else if (link_on && !f_sel_n && clk_rise && bit_cnt_ff != 5'd16) begin
            shift_ff <= {shift_ff[14:0], f_mosi};
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
        end else if (link_on && !f_sel_n && clk_fall) begin
            if (bit_cnt_ff == 5'd8) begin
                rd_ff <= rd_data;
                miso_ff <= rd_data[7];
            end else if (bit_cnt_ff > 5'd8 && bit_cnt_ff < 5'd16) begin
                miso_ff <= rd_ff[3'(~bit_cnt_ff[2:0])];
            end
        end
    end
    assign lnk.lnk_miso = miso_ff;

    // Register file
    logic [7:0] mode_ff, rtp_ff, lib_ff, cfg_a_ff, cfg_b_ff, cfg_c_ff, period_ff;
    logic [7:0] slot_ff [8];
    logic fire_ff;
    wire [2:0] mode_sel = mode_ff[2:0];
    wire standby = mode_ff[`HPK_MODE_STANDBY_BIT];
    wire low_pw = standby | ~f_en;
    wire wr_mode = wr_stb & (rx_addr == `HPK_OFS_MODE);
    wire wr_fire = wr_stb & (rx_addr == `HPK_OFS_FIRE);
    wire hdr_slot = (hdr_addr >= `HPK_OFS_SLOT_FIRST) && (hdr_addr <= `HPK_OFS_SLOT_LAST);
    wire [2:0] hdr_slot_idx = 3'(hdr_addr - `HPK_OFS_SLOT_FIRST);
    wire rx_slot = (rx_addr >= `HPK_OFS_SLOT_FIRST) && (rx_addr <= `HPK_OFS_SLOT_LAST);
    wire [2:0] rx_slot_idx = 3'(rx_addr - `HPK_OFS_SLOT_FIRST);
    wire [7:0] stat_val = 8'(f_nvm) << `HPK_STAT_NVM_BIT;
    assign rd_data = hdr_slot ? slot_ff[hdr_slot_idx] :
                     (hdr_addr == `HPK_OFS_MODE) ? mode_ff :
                     (hdr_addr == `HPK_OFS_RTP) ? rtp_ff :
                     (hdr_addr == `HPK_OFS_LIB) ? lib_ff :
                     (hdr_addr == `HPK_OFS_FIRE) ? {7'h00, fire_ff} :
                     (hdr_addr == `HPK_OFS_CFG_A) ? cfg_a_ff :
                     (hdr_addr == `HPK_OFS_CFG_B) ? cfg_b_ff :
                     (hdr_addr == `HPK_OFS_CFG_C) ? cfg_c_ff :
                     (hdr_addr == `HPK_OFS_STAT) ? stat_val :
                     (hdr_addr == `HPK_OFS_PERIOD) ? period_ff : 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ff <= `HPK_RST_MODE;
            rtp_ff <= 8'h00;
            lib_ff <= 8'h00;
            cfg_a_ff <= `HPK_RST_CFG_A;
            cfg_b_ff <= `HPK_RST_CFG_B;
            cfg_c_ff <= `HPK_RST_CFG_C;
            for (int i = 0; i < 8; i++) slot_ff[i] <= 8'h00;
        end else if (wr_stb) begin
            if (wr_mode) mode_ff <= wr_data;
            if (rx_addr == `HPK_OFS_RTP) rtp_ff <= wr_data;
            if (rx_addr == `HPK_OFS_LIB) lib_ff <= wr_data;
            if (rx_addr == `HPK_OFS_CFG_A) cfg_a_ff <= wr_data;
            if (rx_addr == `HPK_OFS_CFG_B) cfg_b_ff <= wr_data;
            if (rx_addr == `HPK_OFS_CFG_C) cfg_c_ff <= wr_data;
            if (rx_slot) slot_ff[rx_slot_idx] <= wr_data;
        end
    end

    // Effect sequencer for the library trigger modes
    hpk_play_e state_ff;
    logic [2:0] idx_ff;
    logic [$clog2(EFFECT_CYC+1)-1:0] eff_cnt_ff;
    wire lib_mode = (mode_sel == `HPK_MODE_SW_TRIG) || (mode_sel == `HPK_MODE_EDGE_TRIG)
                    || (mode_sel == `HPK_MODE_LEVEL_TRIG);
    wire sw_fire = wr_fire & wr_data[0] & (mode_sel == `HPK_MODE_SW_TRIG);
    wire pin_fire = trig_rise & ((mode_sel == `HPK_MODE_EDGE_TRIG)
                    | (mode_sel == `HPK_MODE_LEVEL_TRIG));
    wire start = (state_ff == HPK_PLAY_IDLE) & ~low_pw & (slot_ff[0] != 8'h00)
                 & (sw_fire | pin_fire);
    wire eff_end = (eff_cnt_ff == ($clog2(EFFECT_CYC+1))'(EFFECT_CYC - 1));
    wire last_slot = (idx_ff == 3'h7) || (slot_ff[3'(idx_ff + 3'h1)] == 8'h00);
    wire abort = low_pw | ~lib_mode | (wr_fire & ~wr_data[0])
                 | ((mode_sel == `HPK_MODE_LEVEL_TRIG) & ~f_trig);
    wire done = (state_ff == HPK_PLAY_RUN) & (abort | (eff_end & last_slot));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= HPK_PLAY_IDLE;
            idx_ff <= '0;
            eff_cnt_ff <= '0;
        end else begin
            unique case (state_ff)
                HPK_PLAY_IDLE: if (start) begin
                    state_ff <= HPK_PLAY_RUN;
                    idx_ff <= '0;
                    eff_cnt_ff <= '0;
                end
                HPK_PLAY_RUN: if (done) begin
                    state_ff <= HPK_PLAY_IDLE;
                end else if (eff_end) begin
                    idx_ff <= idx_ff + 3'h1;
                    eff_cnt_ff <= '0;
                end else begin
                    eff_cnt_ff <= eff_cnt_ff + 1'b1;
                end
            endcase
        end
    end

    // Fire flag: playback start wins over any clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) fire_ff <= 1'b0;
        else if (start) fire_ff <= 1'b1;
        else if (wr_fire && !wr_data[0]) fire_ff <= 1'b0;
        else if (done) fire_ff <= 1'b0;
    end

    // Resonance tracker: flips drive on every back-EMF crossing while drive is active, uses no calibration
    logic [15:0] half_cnt_ff;
    logic pol_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_cnt_ff <= '0;
            pol_ff <= 1'b0;
            period_ff <= 8'h00;
        end else if (!drive_active_o) begin
            half_cnt_ff <= '0;
            pol_ff <= 1'b0;
        end else if (zc_edge) begin
            pol_ff <= ~pol_ff;
            period_ff <= half_cnt_ff[15:8];
            half_cnt_ff <= '0;
        end else if (half_cnt_ff != 16'hffff) begin
            half_cnt_ff <= half_cnt_ff + 16'h0001;
        end
    end

    // Drive outputs
    wire ext_mode = (mode_sel == `HPK_MODE_EXT_INPUT);
    wire rt_mode = (mode_sel == `HPK_MODE_REALTIME);
    wire [7:0] ext_level = cfg_c_ff[`HPK_CFG_C_ANALOG_BIT] ? analog_level
                           : {8{f_trig}};
    wire [7:0] nxt_level = low_pw ? 8'h00 : rt_mode ? rtp_ff : ext_mode ? ext_level
                           : (state_ff == HPK_PLAY_RUN) ? 8'hff : 8'h00;
    wire nxt_active = ~low_pw & (rt_mode | ext_mode | (state_ff == HPK_PLAY_RUN));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_level_o <= 8'h00;
            effect_index_o <= 8'h00;
            effect_library_o <= 8'h00;
            drive_active_o <= 1'b0;
            drive_polarity_o <= 1'b0;
            drive_open_loop_o <= 1'b0;
            drive_bidir_o <= 1'b1;
            low_power_o <= 1'b1;
        end else begin
            drive_level_o <= nxt_level;
            effect_index_o <= (state_ff == HPK_PLAY_RUN) ? slot_ff[idx_ff] : 8'h00;
            effect_library_o <= lib_ff;
            drive_active_o <= nxt_active;
            drive_polarity_o <= pol_ff;
            drive_open_loop_o <= cfg_c_ff[`HPK_CFG_C_OPEN_LOOP_BIT];
            drive_bidir_o <= cfg_b_ff[`HPK_CFG_B_BIDIR_BIT];
            low_power_o <= low_pw;
        end
    end
endmodule : hpk_device

//--- logic/hpk_host.sv
// Host end: AHB-Lite slave registers that drive frames and pins toward the device.
// Assumes one AHB-Lite master on hclk; miso arrives from another domain.
`timescale 1ns/10ps
`include "hpk_consts.svh"
module hpk_host import hpk_pkg::*; #(
    parameter int POWERUP_CYC = `HPK_POWERUP_CYC,
    parameter int HALF_CYC = `HPK_LINK_HALF_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Link to device
    hpk_link_if.host lnk
);
    // Bus address phase capture
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    wire take = hsel & hready & htrans[1];
    logic en_ff, trig_ff, busy_ff, pu_done_ff;
    logic [7:0] rdat_ff;
    wire [31:0] rd_mux = (haddr[7:0] == `HPK_HOFS_CTRL) ? {30'h0, trig_ff, en_ff} :
                         (haddr[7:0] == `HPK_HOFS_STATUS) ?
                         {16'h0, rdat_ff, 6'h00, pu_done_ff, busy_ff} : 32'h0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_ff <= take & hwrite;
            wr_addr_ff <= haddr[7:0];
            if (take && !hwrite) hrdata <= rd_mux;
        end
    end
    wire wr_ctrl = wr_pend_ff & (wr_addr_ff == `HPK_HOFS_CTRL);
    wire wr_cmd = wr_pend_ff & (wr_addr_ff == `HPK_HOFS_CMD);

    // Power-up hold-off before any frame
    logic [$clog2(POWERUP_CYC+1)-1:0] pu_cnt_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pu_cnt_ff <= '0;
            pu_done_ff <= 1'b0;
        end else if (!pu_done_ff) begin
            pu_cnt_ff <= pu_cnt_ff + 1'b1;
            pu_done_ff <= (pu_cnt_ff == ($clog2(POWERUP_CYC+1))'(POWERUP_CYC - 1));
        end
    end

    // Pin control; enable may rise at any time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_ff <= 1'b0;
            trig_ff <= 1'b0;
        end else if (wr_ctrl) begin
            en_ff <= hwdata[0];
            trig_ff <= hwdata[1];
        end
    end
    assign lnk.enable_pin = en_ff;
    assign lnk.input_trigger_pin = trig_ff;

    // Miso synchroniser
    logic m1_ff, m2_ff, m3_ff, mf_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            m1_ff <= 1'b0;
            m2_ff <= 1'b0;
            m3_ff <= 1'b0;
            mf_ff <= 1'b0;
        end else begin
            m1_ff <= lnk.lnk_miso;
            m2_ff <= m1_ff;
            m3_ff <= m2_ff;
            mf_ff <= (m2_ff & m3_ff) | (mf_ff & (m2_ff | m3_ff));
        end
    end

    // Frame engine: link clock made by dividing hclk
    hpk_lnk_e st_ff;
    logic [$clog2(HALF_CYC+1)-1:0] div_ff;
    logic [4:0] nbit_ff;
    logic [15:0] tx_ff;
    logic sclk_ff, sel_n_ff;
    wire tick = (div_ff == ($clog2(HALF_CYC+1))'(HALF_CYC - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= HPK_LNK_IDLE;
            div_ff <= '0;
            nbit_ff <= '0;
            tx_ff <= '0;
            sclk_ff <= 1'b0;
            sel_n_ff <= 1'b1;
            busy_ff <= 1'b0;
            rdat_ff <= 8'h00;
        end else begin
            div_ff <= (st_ff == HPK_LNK_IDLE || tick) ? '0 : div_ff + 1'b1;
            unique case (st_ff)
                HPK_LNK_IDLE: if (wr_cmd && pu_done_ff) begin
                    st_ff <= HPK_LNK_SHIFT;
                    tx_ff <= hwdata[15:0];
                    nbit_ff <= '0;
                    sel_n_ff <= 1'b0;
                    busy_ff <= 1'b1;
                end
                HPK_LNK_SHIFT: if (tick) begin
                    sclk_ff <= ~sclk_ff;
                    if (!sclk_ff) begin
                        nbit_ff <= nbit_ff + 5'd1;
                        if (nbit_ff >= 5'd8) rdat_ff <= {rdat_ff[6:0], mf_ff};
                    end else begin
                        tx_ff <= {tx_ff[14:0], 1'b0};
                        if (nbit_ff == 5'd16) st_ff <= HPK_LNK_END;
                    end
                end
                HPK_LNK_END: if (tick) begin
                    sel_n_ff <= 1'b1;
                    busy_ff <= 1'b0;
                    st_ff <= HPK_LNK_IDLE;
                end
                default: st_ff <= HPK_LNK_IDLE;
            endcase
        end
    end
    assign lnk.lnk_clk = sclk_ff;
    assign lnk.lnk_sel_n = sel_n_ff;
    assign lnk.lnk_mosi = tx_ff[15];
endmodule : hpk_host

//--- test/hpk_link_properties.sv
// Checker for the host-device link wires: idle level, framing, bit timing.
// Assumes the bench instantiates it beside the link interface with the host's HALF_CYC.
`timescale 1ns/10ps
module hpk_link_properties #(
    parameter int HALF_CYC = 16
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link wires
    input wire logic lnk_clk,
    input wire logic lnk_sel_n,
    input wire logic lnk_mosi,
    input wire logic lnk_miso,
    input wire logic enable_pin,
    input wire logic input_trigger_pin
);
    localparam int PER = 2 * HALF_CYC;
    localparam int FRAME_MAX = 40 * HALF_CYC;
    logic [7:0] hi_cnt_ff;
    logic [4:0] rise_cnt_ff;
    logic clk_q_ff;
    wire clk_rise = lnk_clk & ~clk_q_ff;
    wire [7:0] nxt_hi_cnt = lnk_clk ? hi_cnt_ff + 8'h01 : 8'h00;
    wire [4:0] nxt_rise_cnt = lnk_sel_n ? 5'h00 : rise_cnt_ff + {4'h0, clk_rise};
    // Length of each high phase and number of rises in a frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_cnt_ff <= 8'h00;
            rise_cnt_ff <= 5'h00;
            clk_q_ff <= 1'b0;
        end else begin
            hi_cnt_ff <= nxt_hi_cnt;
            rise_cnt_ff <= nxt_rise_cnt;
            clk_q_ff <= lnk_clk;
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence frame_open;
        $fell(lnk_sel_n);
    endsequence
    sequence frame_close;
        $rose(lnk_sel_n);
    endsequence
    AST_CLK_IDLE: assert property (lnk_sel_n |-> !lnk_clk)
        else $error("link clock runs outside a frame");
    AST_LEAD_LOW: assert property (frame_open |-> !lnk_clk [*8])
        else $error("link clock rises too soon after select");
    AST_FRAME_END: assert property (frame_open |->
        (!lnk_sel_n [*8]) ##[1:FRAME_MAX] frame_close)
        else $error("frame select not held or frame too long");
    AST_FRAME_BITS: assert property (frame_close |-> rise_cnt_ff == 5'd16)
        else $error("frame does not carry sixteen bits");
    AST_HIGH_HALF: assert property ($fell(lnk_clk) |-> hi_cnt_ff == HALF_CYC)
        else $error("link clock high phase has wrong length");
    AST_MOSI_HOLD: assert property (lnk_clk |-> $stable(lnk_mosi))
        else $error("host data changes while link clock high");
    AST_RISE_PERIOD: assert property ($rose(lnk_clk) && rise_cnt_ff < 5'd15 |->
        ##[PER:PER] $rose(lnk_clk))
        else $error("link clock period wrong inside a frame");
    AST_TRAIL: assert property (frame_close |-> !$past(lnk_clk) && !$past(lnk_clk, 8))
        else $error("select rises too soon after last clock");
endmodule : hpk_link_properties

//--- test/haptic_playback_mode_sequencer_bench.sv
// Bench for the haptic sequencer: AHB-Lite master drives the host end, which frames the device.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/10ps
`include "hpk_consts.svh"
module haptic_playback_mode_sequencer_bench import hpk_pkg::*;;
    localparam int HALF = 12;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic nvm_programmed = 1'b0;
    logic bemf_zero_cross = 1'b0;
    logic [7:0] analog_level = 8'h00;
    hpk_byte_t drive_level_o, effect_index_o, effect_library_o;
    logic drive_active_o, drive_polarity_o, drive_open_loop_o, drive_bidir_o, low_power_o;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    hpk_byte_t played[$];
    hpk_byte_t idx_q = 8'hxx;
    logic [31:0] rd;
    logic pol;
    hpk_link_if lnk_if();
    hpk_host #(.POWERUP_CYC(20), .HALF_CYC(HALF)) u_hpk_host (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .lnk(lnk_if));
    hpk_device #(.POWERUP_CYC(20), .EFFECT_CYC(600)) u_hpk_device (.hclk(hclk),
        .hresetn(hresetn), .lnk(lnk_if), .nvm_programmed(nvm_programmed),
        .bemf_zero_cross(bemf_zero_cross), .analog_level(analog_level),
        .drive_level_o(drive_level_o), .effect_index_o(effect_index_o),
        .effect_library_o(effect_library_o), .drive_active_o(drive_active_o),
        .drive_polarity_o(drive_polarity_o), .drive_open_loop_o(drive_open_loop_o),
        .drive_bidir_o(drive_bidir_o), .low_power_o(low_power_o));
    hpk_link_properties #(.HALF_CYC(HALF)) u_hpk_link_properties (.hclk(hclk),
        .hresetn(hresetn), .lnk_clk(lnk_if.lnk_clk), .lnk_sel_n(lnk_if.lnk_sel_n),
        .lnk_mosi(lnk_if.lnk_mosi), .lnk_miso(lnk_if.lnk_miso),
        .enable_pin(lnk_if.enable_pin), .input_trigger_pin(lnk_if.input_trigger_pin));
    always #10 hclk = ~hclk;
    // Records each new nonzero effect index; cuts a hang short
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (effect_index_o !== idx_q && effect_index_o !== 8'h00) played.push_back(effect_index_o);
        idx_q <= effect_index_o;
        if (cyc == 90000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // One device frame, then wait for busy to clear and the device to commit
    task automatic dev_wr(input logic [6:0] o, input logic [7:0] d, input logic rw = 1'b0);
        int n;
        ahb(1'b1, `HPK_HOFS_CMD, {16'h0, rw, o, d});
        repeat (2) @(posedge hclk);
        n = 0;
        do begin
            ahb(1'b0, `HPK_HOFS_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 400);
        chk({31'h0, rd[0]}, 32'h0);
        repeat (8) @(posedge hclk);
    endtask : dev_wr
    task automatic rchk(input logic [6:0] o, input logic [7:0] exp);
        dev_wr(o, 8'h00, 1'b1);
        ahb(1'b0, `HPK_HOFS_STATUS, 32'h0);
        chk({24'h0, rd[15:8]}, {24'h0, exp});
    endtask : rchk
    task automatic expect_play(input int n);
        int k;
        k = 0;
        while (drive_active_o !== 1'b0 && k < 8000) begin
            @(posedge hclk);
            k++;
        end
        chk({31'h0, drive_active_o}, 32'h0);
        chk(played.size(), n);
        for (int i = 0; i < n; i++) chk({24'h0, played[i]}, 32'h20 + i);
        played.delete();
    endtask : expect_play
    task automatic pins(input logic [1:0] v);
        ahb(1'b1, `HPK_HOFS_CTRL, {30'h0, v});
        repeat (8) @(posedge hclk);
    endtask : pins
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk({31'h0, drive_bidir_o}, 32'h1);
        chk({31'h0, drive_open_loop_o}, 32'h0);
        ahb(1'b0, `HPK_HOFS_STATUS, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        ahb(1'b1, `HPK_HOFS_CMD, 32'h0100);
        repeat (30) @(posedge hclk);
        pins(2'h1);
        rchk(`HPK_OFS_MODE, 8'h40);
        chk({31'h0, low_power_o}, 32'h1);
        dev_wr(`HPK_OFS_MODE, 8'h00);
        chk({31'h0, low_power_o}, 32'h0);
        for (int v = 0; v < 2; v++) begin
            nvm_programmed <= v[0];
            rchk(`HPK_OFS_STAT, {5'h0, v[0], 2'h0});
        end
        dev_wr(`HPK_OFS_LIB, 8'h03);
        chk({24'h0, effect_library_o}, 32'h3);
        dev_wr(`HPK_OFS_CFG_B, 8'h00);
        chk({31'h0, drive_bidir_o}, 32'h0);
        dev_wr(`HPK_OFS_CFG_C, 8'h01);
        chk({31'h0, drive_open_loop_o}, 32'h1);
        for (int i = 0; i < 8; i++) dev_wr(7'(`HPK_OFS_SLOT_FIRST + i), 8'(8'h20 + i));
        dev_wr(`HPK_OFS_FIRE, 8'h01);
        rchk(`HPK_OFS_FIRE, 8'h01);
        chk({24'h0, drive_level_o}, 32'hff);
        pol = drive_polarity_o;
        bemf_zero_cross <= 1'b1;
        repeat (8) @(posedge hclk);
        chk({31'h0, drive_polarity_o}, {31'h0, ~pol});
        expect_play(8);
        rchk(`HPK_OFS_FIRE, 8'h00);
        dev_wr(`HPK_OFS_FIRE, 8'h01);
        expect_play(8);
        dev_wr(7'(`HPK_OFS_SLOT_FIRST + 2), 8'h00);
        dev_wr(`HPK_OFS_MODE, 8'h01);
        pins(2'h3);
        pins(2'h1);
        expect_play(2);
        dev_wr(`HPK_OFS_MODE, 8'h02);
        pins(2'h3);
        expect_play(2);
        pins(2'h1);
        dev_wr(`HPK_OFS_MODE, 8'h03);
        dev_wr(`HPK_OFS_CFG_C, 8'h03);
        analog_level <= 8'h5a;
        repeat (8) @(posedge hclk);
        chk({24'h0, drive_level_o}, 32'h5a);
        dev_wr(`HPK_OFS_CFG_C, 8'h01);
        pins(2'h3);
        chk({24'h0, drive_level_o}, 32'hff);
        pins(2'h1);
        chk({24'h0, drive_level_o}, 32'h00);
        dev_wr(`HPK_OFS_MODE, 8'h05);
        for (int i = 0; i < 2; i++) begin
            dev_wr(`HPK_OFS_RTP, 8'(8'h33 + 8'(i) * 8'h4c));
            chk({24'h0, drive_level_o}, 32'h33 + i * 32'h4c);
        end
        dev_wr(`HPK_OFS_MODE, 8'h41);
        chk({31'h0, low_power_o}, 32'h1);
        rchk(`HPK_OFS_MODE, 8'h41);
        dev_wr(`HPK_OFS_MODE, 8'h00);
        pins(2'h0);
        chk({31'h0, low_power_o}, 32'h1);
        tally_and_finish();
    end
endmodule : haptic_playback_mode_sequencer_bench
